//--- bsc_pkg.sv
// constants, states and carrier types of the burner sequence controller
package bsc_pkg;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS         = 1;

  localparam int PREPURGE_MS     = 35000;
  localparam int IGN_WAIT_MS     = 2000;
  localparam int IGN_TRIAL_MS    = 3000;
  localparam int PILOT_STAB_MS   = 5000;
  localparam int MAIN_TRIAL_MS   = 3000;
  localparam int LOCKOUT_MS      = 20000;
  localparam int AIRFLOW_WAIT_MS = 300000;

  localparam int PREPURGE_TICKS     = PREPURGE_MS / TICK_MS;
  localparam int IGN_WAIT_TICKS     = IGN_WAIT_MS / TICK_MS;
  localparam int IGN_TRIAL_TICKS    = IGN_TRIAL_MS / TICK_MS;
  localparam int PILOT_STAB_TICKS   = PILOT_STAB_MS / TICK_MS;
  localparam int MAIN_TRIAL_TICKS   = MAIN_TRIAL_MS / TICK_MS;
  localparam int LOCKOUT_TICKS      = LOCKOUT_MS / TICK_MS;
  localparam int AIRFLOW_WAIT_TICKS = AIRFLOW_WAIT_MS / TICK_MS;
  localparam int TMR_W              = 19;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  localparam int CTRL_RESET_BIT    = 0;
  localparam int STATUS_STATE_LSB  = 0;
  localparam int STATUS_CAUSE_LSB  = 8;
  localparam int STATUS_MODE_BIT   = 16;
  localparam int STATUS_ALARM_BIT  = 17;
  localparam int STATUS_FLAME_BIT  = 18;
  localparam int STATUS_RESET_VAL  = 0;

  typedef enum logic [3:0] {
    ST_STANDBY, ST_AIR_WAIT, ST_PREPURGE, ST_IGN_WAIT, ST_IGN_TRIAL, ST_PILOT_STAB,
    ST_MAIN_TRIAL, ST_RUN, ST_POSTRUN, ST_LOCK_WAIT, ST_LOCKOUT
  } bsc_state_e;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_SAFETY, CAUSE_AIR_TIMEOUT, CAUSE_AIR_LOST, CAUSE_FLAME_EARLY,
    CAUSE_IGN_FAIL, CAUSE_FLAME_LOST
  } bsc_cause_e;

  typedef struct packed {
    logic heat_demand;
    logic airflow_switch_input;
    logic safety_closed;
    logic flame_sensed;
    logic direct_main_ignition_mode;
  } bsc_field_in_s;

  typedef struct packed {
    logic blower_output;
    logic ignition_output;
    logic intermittent_pilot_output;
    logic interrupted_pilot_output;
    logic main_valve_output;
    logic flame_indicator;
    logic lockout_alarm;
  } bsc_field_out_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bsc_bus_req_s;

endpackage : bsc_pkg

//--- bsc_tick_timer.sv
// down counter stepped by the prescaled tick, loaded on state entry
`timescale 1ns/100ps
module bsc_tick_timer #(
  parameter int W = 19
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (tick && (cnt_reg != '0)) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);

endmodule : bsc_tick_timer

//--- bsc_burner_ctrl.sv
// burner sequence state machine with register port
// Notes on behaviour
// R01 - Safety loop open sends the sequence into lockout at once, any state.
// R02 - Mode input high selects direct main ignition, otherwise pilot ignition.
// R03 - Direct mode: no main trial, go straight to run after stabilisation.
// R04 - Pilot mode: separate main burner trial after pilot stabilises.
// R05 - Start only with no flame, air switch open and safety loop closed.
// R06 - Heat demand from standby switches the blower on.
// R07 - Air switch closing after blower start begins pre-purge timing.
// R08 - Pre-purge end is followed by a two second ignition wait.
// R09 - Wait end energises ignition and both pilot outputs.
// R10 - Flame at end of first trial window starts pilot stabilisation.
// R11 - Stabilisation end opens main valves and starts main trial window.
// R12 - Main trial end drops interrupted pilot, keeps intermittent pilot and main.
// R13 - Demand removed in run drops intermittent pilot, main valves and blower.
// R14 - With demand gone and air switch open, return to standby.
// R15 - Lockout holds twenty seconds, reset requests ignored until then.
// R16 - Flame loss or air switch opening in ignition or run locks out.
// R17 - Air switch still open five minutes after demand flags an error.
// R18 - No flame at end of first trial window is ignition failure.
// R19 - Phase durations come from a prescaled clock tick counter.
// R20 - Flame indicator follows flame from ignition on, off in standby and purge.
`timescale 1ns/100ps
module bsc_burner_ctrl
  import bsc_pkg::*;
#(
  parameter int TICK_CYCLES_P = bsc_pkg::TICK_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire bsc_pkg::bsc_field_in_s         field_in,
  output bsc_pkg::bsc_field_out_s             field_out,
  input  wire bsc_pkg::bsc_bus_req_s          bus_req,
  output logic [bsc_pkg::DATA_W-1:0]          rd_data
);
  import bsc_pkg::*;

  if (TICK_CYCLES_P < 2) begin : g_chk
    $error("TICK_CYCLES_P must be at least 2");
  end

  localparam int PW = $clog2(TICK_CYCLES_P);

  // prescaler
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic          tick_reg;
  logic          tick_next;

  always_comb begin
    tick_next = (pre_reg == PW'(TICK_CYCLES_P - 1)); // R19
    pre_next  = tick_next ? '0 : pre_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // sequence
  bsc_state_e       st_reg;
  bsc_state_e       st_next;
  bsc_cause_e       cause_reg;
  bsc_cause_e       cause_next;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;
  logic             reset_req;
  logic             mode_direct;
  logic             air;
  logic             flame;

  assign reset_req   = bus_req.wr && (bus_req.addr == OFS_CTRL)
                       && bus_req.wdata[CTRL_RESET_BIT];
  assign mode_direct = field_in.direct_main_ignition_mode; // R02
  assign air         = field_in.airflow_switch_input;
  assign flame       = field_in.flame_sensed;

  function automatic logic [TMR_W-1:0] dur_of(input bsc_state_e s);
    unique case (s)
      ST_AIR_WAIT:   dur_of = TMR_W'(AIRFLOW_WAIT_TICKS); // R17
      ST_PREPURGE:   dur_of = TMR_W'(PREPURGE_TICKS);     // R19
      ST_IGN_WAIT:   dur_of = TMR_W'(IGN_WAIT_TICKS);     // R08
      ST_IGN_TRIAL:  dur_of = TMR_W'(IGN_TRIAL_TICKS);
      ST_PILOT_STAB: dur_of = TMR_W'(PILOT_STAB_TICKS);
      ST_MAIN_TRIAL: dur_of = TMR_W'(MAIN_TRIAL_TICKS);
      ST_LOCK_WAIT:  dur_of = TMR_W'(LOCKOUT_TICKS);      // R15
      default:       dur_of = '0;
    endcase
  endfunction : dur_of

  always_comb begin
    st_next    = st_reg;
    cause_next = cause_reg;
    if (!field_in.safety_closed && (st_reg != ST_LOCK_WAIT) && (st_reg != ST_LOCKOUT)) begin
      st_next    = ST_LOCK_WAIT; // R01
      cause_next = CAUSE_SAFETY;
    end else begin
      unique case (st_reg)
        ST_STANDBY: begin
          if (field_in.heat_demand && !flame && !air) begin // R05
            st_next    = ST_AIR_WAIT; // R06
            cause_next = CAUSE_NONE;
          end
        end
        ST_AIR_WAIT: begin
          if (!field_in.heat_demand) begin
            st_next = ST_POSTRUN;
          end else if (air) begin
            st_next = ST_PREPURGE; // R07
          end else if (tmr_done) begin
            st_next    = ST_LOCK_WAIT; // R17
            cause_next = CAUSE_AIR_TIMEOUT;
          end
        end
        ST_PREPURGE, ST_IGN_WAIT: begin
          if (!air) begin
            st_next    = ST_LOCK_WAIT;
            cause_next = CAUSE_AIR_LOST;
          end else if (flame) begin
            st_next    = ST_LOCK_WAIT;
            cause_next = CAUSE_FLAME_EARLY;
          end else if (tmr_done) begin
            st_next = (st_reg == ST_PREPURGE) ? ST_IGN_WAIT : ST_IGN_TRIAL; // R08 R09
          end
        end
        ST_IGN_TRIAL: begin
          if (!air) begin
            st_next    = ST_LOCK_WAIT; // R16
            cause_next = CAUSE_AIR_LOST;
          end else if (tmr_done) begin
            if (flame) begin
              st_next = ST_PILOT_STAB; // R10
            end else begin
              st_next    = ST_LOCK_WAIT; // R18
              cause_next = CAUSE_IGN_FAIL;
            end
          end
        end
        ST_PILOT_STAB, ST_MAIN_TRIAL, ST_RUN: begin
          if (!air) begin
            st_next    = ST_LOCK_WAIT; // R16
            cause_next = CAUSE_AIR_LOST;
          end else if (!flame) begin
            st_next    = ST_LOCK_WAIT; // R16
            cause_next = CAUSE_FLAME_LOST;
          end else if (st_reg == ST_RUN) begin
            if (!field_in.heat_demand) begin
              st_next = ST_POSTRUN; // R13
            end
          end else if (tmr_done) begin
            if (st_reg == ST_MAIN_TRIAL || mode_direct) begin
              st_next = ST_RUN; // R03 R12
            end else begin
              st_next = ST_MAIN_TRIAL; // R04 R11
            end
          end
        end
        ST_POSTRUN: begin
          if (!air) begin
            st_next = ST_STANDBY; // R14
          end
        end
        ST_LOCK_WAIT: begin
          if (tmr_done) begin
            st_next = ST_LOCKOUT; // R15
          end
        end
        ST_LOCKOUT: begin
          if (reset_req && field_in.safety_closed) begin
            st_next    = ST_STANDBY;
            cause_next = CAUSE_NONE;
          end
        end
        default: begin
          st_next    = ST_LOCK_WAIT;
          cause_next = CAUSE_SAFETY;
        end
      endcase
    end
    tmr_load = (st_next != st_reg);
    tmr_val  = dur_of(st_next);
  end

  bsc_tick_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick_reg),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // outputs follow the next state
  bsc_field_out_s out_next;
  logic           ign_on;

  always_comb begin
    ign_on   = (st_next inside {ST_IGN_TRIAL, ST_PILOT_STAB, ST_MAIN_TRIAL, ST_RUN});
    out_next.blower_output             = ign_on || (st_next inside {ST_AIR_WAIT, ST_PREPURGE,
                                                                    ST_IGN_WAIT}); // R13
    out_next.ignition_output           = (st_next == ST_IGN_TRIAL); // R09
    out_next.intermittent_pilot_output = ign_on; // R09 R12
    out_next.interrupted_pilot_output  = (st_next inside {ST_IGN_TRIAL, ST_PILOT_STAB,
                                                          ST_MAIN_TRIAL}); // R12
    out_next.main_valve_output         = (st_next inside {ST_MAIN_TRIAL, ST_RUN}); // R11
    out_next.flame_indicator           = flame && (ign_on || st_next == ST_POSTRUN); // R20
    out_next.lockout_alarm             = (st_next inside {ST_LOCK_WAIT, ST_LOCKOUT});
  end

  // register read
  logic [DATA_W-1:0] rd_next;

  always_comb begin
    rd_next = '0;
    if (bus_req.rd && (bus_req.addr == OFS_STATUS)) begin
      rd_next[STATUS_STATE_LSB +: 4] = st_reg;
      rd_next[STATUS_CAUSE_LSB +: 3] = cause_reg;
      rd_next[STATUS_MODE_BIT]       = mode_direct;
      rd_next[STATUS_ALARM_BIT]      = field_out.lockout_alarm;
      rd_next[STATUS_FLAME_BIT]      = flame;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= ST_STANDBY;
      cause_reg <= CAUSE_NONE;
      field_out <= '0;
      rd_data   <= DATA_W'(STATUS_RESET_VAL);
    end else begin
      st_reg    <= st_next;
      cause_reg <= cause_next;
      field_out <= out_next;
      rd_data   <= rd_next;
    end
  end

  // checks
  sequence s_start_ok;
    st_reg == ST_STANDBY && field_in.heat_demand && !flame && !air && field_in.safety_closed;
  endsequence

  sequence s_stab_end;
    st_reg == ST_PILOT_STAB && tmr_done && flame && air && field_in.safety_closed;
  endsequence

  property p_safety_lock;
    @(posedge clk) disable iff (!rst_n)
      !field_in.safety_closed |=> field_out.lockout_alarm && !field_out.blower_output
                                 && !field_out.main_valve_output;
  endproperty
  a_safety_lock: assert property (p_safety_lock) else $error("safety open without lockout"); // R01

  property p_direct_run;
    @(posedge clk) disable iff (!rst_n)
      s_stab_end ##0 mode_direct |=> st_reg == ST_RUN && !field_out.interrupted_pilot_output;
  endproperty
  a_direct_run: assert property (p_direct_run) else $error("direct mode did not go to run"); // R03

  property p_pilot_main;
    @(posedge clk) disable iff (!rst_n)
      s_stab_end ##0 !mode_direct |=> st_reg == ST_MAIN_TRIAL && field_out.main_valve_output;
  endproperty
  a_pilot_main: assert property (p_pilot_main) else $error("pilot mode skipped main trial"); // R04

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      s_start_ok |=> st_reg == ST_AIR_WAIT && field_out.blower_output;
  endproperty
  a_start: assert property (p_start) else $error("start from standby failed"); // R06

  property p_no_start;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_STANDBY && (flame || air) |=> st_reg == ST_STANDBY;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start with flame or air closed"); // R05

  property p_purge;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_AIR_WAIT && air && field_in.heat_demand && field_in.safety_closed
      |=> st_reg == ST_PREPURGE;
  endproperty
  a_purge: assert property (p_purge) else $error("air closed without pre-purge"); // R07

  property p_ignite;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_IGN_WAIT && tmr_done && air && !flame && field_in.safety_closed
      |=> field_out.ignition_output && field_out.intermittent_pilot_output
          && field_out.interrupted_pilot_output;
  endproperty
  a_ignite: assert property (p_ignite) else $error("ignition outputs not energised"); // R09

  property p_ign_fail;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_IGN_TRIAL && tmr_done && !flame |=> st_reg == ST_LOCK_WAIT;
  endproperty
  a_ign_fail: assert property (p_ign_fail) else $error("ignition failure not locked out"); // R18

  property p_reset_ignored;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_LOCK_WAIT && reset_req |=> st_reg != ST_STANDBY;
  endproperty
  a_reset_ignored: assert property (p_reset_ignored) else $error("reset taken too early"); // R15

  property p_run_off;
    @(posedge clk) disable iff (!rst_n)
      st_reg == ST_RUN && !field_in.heat_demand && air && flame && field_in.safety_closed
      |=> !field_out.main_valve_output && !field_out.blower_output
          ##1 !field_out.intermittent_pilot_output;
  endproperty
  a_run_off: assert property (p_run_off) else $error("demand off left outputs on"); // R13

  property p_indicator;
    @(posedge clk) disable iff (!rst_n)
      st_reg inside {ST_STANDBY, ST_AIR_WAIT, ST_PREPURGE} |-> !field_out.flame_indicator;
  endproperty
  a_indicator: assert property (p_indicator) else $error("flame indicator lit early"); // R20

endmodule : bsc_burner_ctrl

//--- bsc_field_model.sv
// field side model: air flow switch behind the blower and a flame sensor
`timescale 1ns/100ps
module bsc_field_model
  import bsc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire bsc_pkg::bsc_field_out_s field_out,
  input  wire logic                    air_stuck,
  input  wire logic                    flame_stuck,
  output logic                         air_closed,
  output logic                         flame
);
  logic [2:0] air_cnt;
  logic [1:0] fl_cnt;
  logic       pilot_on;
  logic       valve_on;

  assign pilot_on   = field_out.intermittent_pilot_output | field_out.interrupted_pilot_output;
  assign valve_on   = pilot_on | field_out.main_valve_output;
  assign air_closed = air_stuck | (air_cnt == 3'h4);
  assign flame      = flame_stuck | (fl_cnt == 2'h3);

  // air builds up a few cycles after the blower starts, decays after it stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      air_cnt <= 3'h0;
      fl_cnt  <= 2'h0;
    end else begin
      if (field_out.blower_output && air_cnt != 3'h4) begin
        air_cnt <= air_cnt + 3'h1;
      end else if (!field_out.blower_output && air_cnt != 3'h0) begin
        air_cnt <= air_cnt - 3'h1;
      end
      // flame lights under spark and pilot, dies when all fuel is shut
      if (!valve_on) begin
        fl_cnt <= 2'h0;
      end else if (field_out.ignition_output && pilot_on && fl_cnt != 2'h3) begin
        fl_cnt <= fl_cnt + 2'h1;
      end
    end
  end
endmodule : bsc_field_model

//--- tb_top.sv
// self-checking bench of the burner sequence controller
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import bsc_pkg::*;
  localparam int TK    = 2;
  localparam int LIMIT = 98000;
  logic           clk;
  logic           rst_n;
  logic           heat, safe, mode, air, flame, air_stuck, flame_stuck;
  bsc_field_in_s  field_in;
  bsc_field_out_s field_out;
  bsc_bus_req_s   bus_req;
  logic [31:0]    rd_data;
  logic [31:0]    d;
  int             fails, cmp_count, cyc, n;

  logic           air_d, flame_d, air_nf, flame_cut;
  bsc_field_in_s  fin_dbi, fin_nf;
  bsc_field_out_s fout_dbi, fout_nf;

  assign field_in = '{heat, air, safe, flame, mode};
  // direct mode twin, flame can be cut
  assign fin_dbi  = '{heat, air_d, safe, flame_d & ~flame_cut, 1'b1};
  // twin that never sees a flame once ignition starts
  assign fin_nf   = '{heat, air_nf, safe, flame_stuck, mode};

  bsc_burner_ctrl #(.TICK_CYCLES_P(TK)) dut (.clk(clk), .rst_n(rst_n), .field_in(field_in),
    .field_out(field_out), .bus_req(bus_req), .rd_data(rd_data));
  bsc_field_model model (.clk(clk), .rst_n(rst_n), .field_out(field_out),
    .air_stuck(air_stuck), .flame_stuck(flame_stuck), .air_closed(air), .flame(flame));
  bsc_burner_ctrl #(.TICK_CYCLES_P(TK)) dut_dbi (.clk(clk), .rst_n(rst_n), .field_in(fin_dbi),
    .field_out(fout_dbi), .bus_req(bus_req), .rd_data());
  bsc_field_model model_dbi (.clk(clk), .rst_n(rst_n), .field_out(fout_dbi),
    .air_stuck(air_stuck), .flame_stuck(flame_stuck), .air_closed(air_d), .flame(flame_d));
  bsc_burner_ctrl #(.TICK_CYCLES_P(TK)) dut_nf (.clk(clk), .rst_n(rst_n), .field_in(fin_nf),
    .field_out(fout_nf), .bus_req(bus_req), .rd_data());
  bsc_field_model model_nf (.clk(clk), .rst_n(rst_n), .field_out(fout_nf),
    .air_stuck(air_stuck), .flame_stuck(flame_stuck), .air_closed(air_nf), .flame());

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  function automatic logic [31:0] st(logic [3:0] s, logic [2:0] c, logic al, logic fl);
    return {13'h0000, fl, al, mode, 5'h00, c, 4'h0, s};
  endfunction : st

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cycles

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '{a, v, 1'b0, 1'b0};
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b0};
    #1 v = rd_data;
  endtask : bus_rd

  task automatic wait_bit(input int idx, input logic v, input int lim);
    n = 0;
    while (field_out[idx] !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_bit

  task automatic test_idle();
    @(posedge clk) mode <= 1'b1;
    bus_rd(4'h4, d);
    `CHK(d, st(4'h0, 3'h0, 1'b0, 1'b0))
    @(posedge clk) mode <= 1'b0;
    bus_rd(4'h4, d);
    `CHK(d, st(4'h0, 3'h0, 1'b0, 1'b0))
    cycles(1);
    `CHK(rd_data, 32'h0000_0000)
    bus_rd(4'h8, d);
    `CHK(d, 32'h0000_0000)
    bus_rd(4'h0, d);
    `CHK(d, 32'h0000_0000)
    $display("test idle done");
  endtask : test_idle

  task automatic test_refuse();
    @(posedge clk);
    flame_stuck <= 1'b1;
    heat        <= 1'b1;
    cycles(8);
    `CHK(field_out, 7'h00)
    bus_rd(4'h4, d);
    `CHK(d, st(4'h0, 3'h0, 1'b0, 1'b1))
    @(posedge clk);
    flame_stuck <= 1'b0;
    air_stuck   <= 1'b1;
    cycles(8);
    `CHK(field_out, 7'h00)
    @(posedge clk);
    heat      <= 1'b0;
    air_stuck <= 1'b0;
    cycles(6);
    $display("test refuse done");
  endtask : test_refuse

  task automatic test_lock();
    @(posedge clk) heat <= 1'b1;
    wait_bit(6, 1'b1, 4);
    `CHK(field_out, 7'h40)
    cycles(8);
    bus_rd(4'h4, d);
    `CHK(d, st(4'h2, 3'h0, 1'b0, 1'b0))
    @(posedge clk) safe <= 1'b0;
    cycles(2);
    `CHK(field_out, 7'h01)
    bus_rd(4'h4, d);
    `CHK(d, st(4'h9, 3'h1, 1'b1, 1'b0))
    @(posedge clk) safe <= 1'b1;
    bus_wr(4'h0, 32'h0000_0001);
    bus_rd(4'h4, d);
    `CHK(d, st(4'h9, 3'h1, 1'b1, 1'b0))
    @(posedge clk);
    heat  <= 1'b0;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cycles(2);
    `CHK(field_out, 7'h00)
    $display("test lock done");
  endtask : test_lock

  task automatic test_run();
    @(posedge clk) heat <= 1'b1;
    wait_bit(6, 1'b1, 4);
    wait_bit(5, 1'b1, 80000);
    `CHK(n >= (PREPURGE_TICKS + IGN_WAIT_TICKS - 2) * TK, 1'b1)
    `CHK(field_out, 7'h78)
    wait_bit(5, 1'b0, IGN_TRIAL_TICKS * TK + 8);
    `CHK(n >= (IGN_TRIAL_TICKS - 1) * TK, 1'b1)
    `CHK(field_out, 7'h5A)
    `CHK(fout_nf, 7'h01)
    wait_bit(2, 1'b1, PILOT_STAB_TICKS * TK + 8);
    `CHK(n >= (PILOT_STAB_TICKS - 1) * TK, 1'b1)
    `CHK(field_out, 7'h5E)
    `CHK(fout_dbi, 7'h56)
    wait_bit(3, 1'b0, MAIN_TRIAL_TICKS * TK + 8);
    `CHK(n >= (MAIN_TRIAL_TICKS - 1) * TK, 1'b1)
    `CHK(field_out, 7'h56)
    bus_rd(4'h4, d);
    `CHK(d, st(4'h7, 3'h0, 1'b0, 1'b1))
    `CHK(fout_dbi, 7'h56)
    @(posedge clk) flame_cut <= 1'b1;
    cycles(2);
    `CHK(fout_dbi, 7'h01)
    `CHK(field_out, 7'h56)
    @(posedge clk) heat <= 1'b0;
    wait_bit(6, 1'b0, 4);
    `CHK(7'(field_out) & 7'h7C, 7'h00)
    cycles(12);
    `CHK(field_out, 7'h00)
    bus_rd(4'h4, d);
    `CHK(d, st(4'h0, 3'h0, 1'b0, 1'b0))
    $display("test run done");
  endtask : test_run

  initial begin
    rst_n       = 1'b0;
    heat        = 1'b0;
    safe        = 1'b1;
    mode        = 1'b0;
    air_stuck   = 1'b0;
    flame_stuck = 1'b0;
    bus_req     = '0;
    fails       = 0;
    cmp_count   = 0;
    cyc         = 0;
    flame_cut   = 1'b0;
    fork
      begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cycles(1);
        test_idle();
        test_refuse();
        test_lock();
        test_run();
      end
      begin
        while (cyc < LIMIT) begin
          @(posedge clk);
          cyc++;
        end
        fails++;
      end
    join_any
    complete_run();
  end
endmodule : tb_top
